// ==== bsle_exec.sv ====
// Purpose: Executes branches, skips, compares, calls and data loads
// Assumes: Data, I/O and stack reads answer in the same cycle as the request and hold
// Notes: Results and done pulse leave together from flip-flops
`timescale 1ns/1ps
`include "bsle_map.svh"
module bsle_exec #(
   parameter int CALL_CYCLES = `BSLE_CYC_CALL,
   parameter int RETURN_CYCLES = `BSLE_CYC_RETURN
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input bsle_pkg::bsle_instr_t in_instr,
   input wire logic [7:0] status_register,
   input wire logic [7:0] mem_rdata,
   input wire logic [15:0] stk_rdata,
   output bsle_pkg::bsle_mem_t mem_req,
   output bsle_pkg::bsle_stack_t stk_req,
   output bsle_pkg::bsle_result_t result
);
   import bsle_pkg::*;

   // Counter is three bits wide, so longer counts cannot be served
   if (CALL_CYCLES < 1 || CALL_CYCLES > 7 || RETURN_CYCLES < 1 || RETURN_CYCLES > 7)
   begin : g_cycle_check
      $error("cycle parameters out of range");
   end

   typedef struct packed {
      bsle_fsm_t fsm;
      logic [2:0] cnt;
      logic ext;
      bsle_instr_t ins;
      logic [15:0] pc_tgt;
      logic [7:0] flg;
      bsle_mem_t mem;
      bsle_stack_t stk;
      bsle_result_t res;
   } bsle_state_t;

   bsle_state_t s_r;
   bsle_state_t s_nxt;
   logic finish;
   logic io_skip;
   logic last;
   logic take;

   // Branch condition from the status register
   function automatic logic br_cond(input bsle_op_t op, input logic [7:0] f,
                                    input logic [2:0] s);
      logic c;
      c = 1'b0;
      case (op)
         op_branch_flag_set: c = f[s];
         op_branch_flag_clear: c = ~f[s];
         op_branch_lower: c = f[`BSLE_STATUS_REGISTER_C];
         op_branch_same_higher: c = ~f[`BSLE_STATUS_REGISTER_C];
         op_branch_signed_ge: c = ~(f[`BSLE_STATUS_REGISTER_N] ^ f[`BSLE_STATUS_REGISTER_V]);
         op_branch_signed_lt: c = f[`BSLE_STATUS_REGISTER_N] ^ f[`BSLE_STATUS_REGISTER_V];
         op_branch_halfcarry_set: c = f[`BSLE_STATUS_REGISTER_H];
         op_branch_halfcarry_clear: c = ~f[`BSLE_STATUS_REGISTER_H];
         op_branch_transfer_bit_set: c = f[`BSLE_STATUS_REGISTER_T];
         op_branch_transfer_bit_clear: c = ~f[`BSLE_STATUS_REGISTER_T];
         op_branch_overflow_set: c = f[`BSLE_STATUS_REGISTER_V];
         op_branch_overflow_clear: c = ~f[`BSLE_STATUS_REGISTER_V];
         op_branch_irq_enabled: c = f[`BSLE_STATUS_REGISTER_I];
         op_branch_irq_disabled: c = ~f[`BSLE_STATUS_REGISTER_I];
         default: c = 1'b0;
      endcase
      return c;
   endfunction

   // Subtraction flags for the compare family
   function automatic logic [7:0] cmp_flags(input bsle_instr_t i, input logic [7:0] f);
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic [7:0] o;
      logic cin;
      a = i.rd_val;
      b = (i.op == op_compare_imm) ? i.imm : i.rr_val;
      cin = (i.op == op_compare_carry) ? f[`BSLE_STATUS_REGISTER_C] : 1'b0;
      r = a - b - {7'h00, cin};
      o = f;
      o[`BSLE_STATUS_REGISTER_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o[`BSLE_STATUS_REGISTER_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[`BSLE_STATUS_REGISTER_N] = r[7];
      o[`BSLE_STATUS_REGISTER_S] = r[7] ^ o[`BSLE_STATUS_REGISTER_V];
      o[`BSLE_STATUS_REGISTER_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      // With carry the zero flag only stays set when already set
      if (i.op == op_compare_carry)
         o[`BSLE_STATUS_REGISTER_Z] = (r == 8'h00) & f[`BSLE_STATUS_REGISTER_Z];
      else
         o[`BSLE_STATUS_REGISTER_Z] = (r == 8'h00);
      return o;
   endfunction

   // End of the current instruction and the late I/O skip decision
   always_comb
   begin
      finish = (s_r.fsm == st_run) && (s_r.cnt == 3'h1);
      io_skip = 1'b0;
      if (s_r.ins.op == op_skip_io_bit_clear)
         io_skip = ~mem_rdata[s_r.ins.bit_sel];
      else if (s_r.ins.op == op_skip_io_bit_set)
         io_skip = mem_rdata[s_r.ins.bit_sel];
      last = finish && !(io_skip && !s_r.ext);
      in_ready = (s_r.fsm == st_idle) || last;
      take = in_valid && in_ready;
   end

   // Next state: finish the running instruction, then accept a new one
   always_comb
   begin
      logic cond;
      logic [15:0] skip_pc;
      logic [2:0] skip_cyc;
      cond = 1'b0;
      skip_pc = 16'h0000;
      skip_cyc = 3'h0;
      s_nxt = s_r;
      s_nxt.res.done = 1'b0;
      s_nxt.res.reg_we = 1'b0;
      s_nxt.res.ptr_we = 1'b0;
      s_nxt.res.status_register_we = 1'b0;
      s_nxt.mem.rd = 1'b0;
      s_nxt.stk.push = 1'b0;
      s_nxt.stk.pop = 1'b0;
      if (s_r.fsm == st_run && !finish)
         s_nxt.cnt = s_r.cnt - 3'h1;
      if (finish && !last)
      begin
         // I/O skip taken: stretch by the size of the skipped instruction
         s_nxt.ext = 1'b1;
         s_nxt.cnt = s_r.ins.next_two_words ? 3'h2 : 3'h1;
         s_nxt.pc_tgt = s_r.ins.pc + (s_r.ins.next_two_words ? 16'h0003 : 16'h0002);
      end
      else if (finish)
      begin
         s_nxt.fsm = st_idle;
         s_nxt.res.done = 1'b1;
         s_nxt.res.pc_val = s_r.pc_tgt;
         case (s_r.ins.op)
            op_direct_load, op_indirect_load:
            begin
               s_nxt.res.reg_we = 1'b1;
               s_nxt.res.reg_wdata = mem_rdata;
            end
            op_indirect_load_inc, op_indirect_load_dec:
            begin
               s_nxt.res.reg_we = 1'b1;
               s_nxt.res.reg_wdata = mem_rdata;
               s_nxt.res.ptr_we = 1'b1;
               s_nxt.res.ptr_wdata = s_r.mem.addr;
               if (s_r.ins.op == op_indirect_load_inc)
                  s_nxt.res.ptr_wdata = s_r.mem.addr + 16'h0001;
               s_nxt.res.pc_val = s_r.ins.pc + 16'h0001;
            end
            op_return, op_interrupt_return:
            begin
               s_nxt.res.pc_val = stk_rdata;
               if (s_r.ins.op == op_interrupt_return)
               begin
                  s_nxt.res.status_register_we = 1'b1;
                  s_nxt.res.status_register_val = status_register | (8'h01 << `BSLE_STATUS_REGISTER_I);
               end
            end
            op_compare, op_compare_carry, op_compare_imm:
            begin
               s_nxt.res.status_register_we = 1'b1;
               s_nxt.res.status_register_val = s_r.flg;
            end
            default:
            begin
               s_nxt.res.reg_we = 1'b0;
            end
         endcase
      end
      if (take)
      begin
         s_nxt.fsm = st_run;
         s_nxt.ext = 1'b0;
         s_nxt.ins = in_instr;
         s_nxt.pc_tgt = in_instr.pc + 16'h0001;
         skip_pc = in_instr.pc + (in_instr.next_two_words ? 16'h0003 : 16'h0002);
         skip_cyc = in_instr.next_two_words ? 3'h3 : 3'h2;
         cond = br_cond(in_instr.op, status_register, in_instr.bit_sel);
         case (in_instr.op)
            op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set:
            begin
               if (in_instr.op == op_compare_skip_equal)
                  cond = (in_instr.rd_val == in_instr.rr_val);
               else if (in_instr.op == op_skip_reg_bit_clear)
                  cond = ~in_instr.rr_val[in_instr.bit_sel];
               else
                  cond = in_instr.rr_val[in_instr.bit_sel];
               s_nxt.cnt = cond ? skip_cyc : 3'(`BSLE_CYC_SKIP_REG);
               if (cond)
                  s_nxt.pc_tgt = skip_pc;
            end
            op_skip_io_bit_clear, op_skip_io_bit_set:
            begin
               s_nxt.cnt = 3'(`BSLE_CYC_SKIP_IO);
               s_nxt.mem.rd = 1'b1;
               s_nxt.mem.io = 1'b1;
               s_nxt.mem.addr = in_instr.addr;
            end
            op_direct_load:
            begin
               s_nxt.cnt = 3'(`BSLE_CYC_LOAD_DIRECT);
               s_nxt.mem.rd = 1'b1;
               s_nxt.mem.io = 1'b0;
               s_nxt.mem.addr = in_instr.addr;
               s_nxt.pc_tgt = in_instr.pc + 16'h0002;
            end
            op_indirect_load, op_indirect_load_inc:
            begin
               s_nxt.cnt = 3'(`BSLE_CYC_LOAD_PLAIN);
               s_nxt.mem.rd = 1'b1;
               s_nxt.mem.io = 1'b0;
               s_nxt.mem.addr = in_instr.ptr;
            end
            op_indirect_load_dec:
            begin
               s_nxt.cnt = 3'(`BSLE_CYC_LOAD_DEC);
               s_nxt.mem.rd = 1'b1;
               s_nxt.mem.io = 1'b0;
               s_nxt.mem.addr = in_instr.ptr - 16'h0001;
            end
            op_call:
            begin
               s_nxt.cnt = 3'(CALL_CYCLES);
               s_nxt.stk.push = 1'b1;
               s_nxt.stk.wdata = in_instr.pc + 16'h0002;
               s_nxt.pc_tgt = in_instr.addr;
            end
            op_return, op_interrupt_return:
            begin
               s_nxt.cnt = 3'(RETURN_CYCLES);
               s_nxt.stk.pop = 1'b1;
            end
            op_compare, op_compare_carry, op_compare_imm:
            begin
               s_nxt.cnt = 3'(`BSLE_CYC_COMPARE);
               s_nxt.flg = cmp_flags(in_instr, status_register);
            end
            default:
            begin
               // Branches; anything else retires as a one-cycle step
               s_nxt.cnt = 3'(`BSLE_CYC_BRANCH) + {2'b00, cond};
               if (cond)
                  s_nxt.pc_tgt = in_instr.pc + {{9{in_instr.offset[6]}}, in_instr.offset}
                                 + 16'h0001;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '0;
         s_r.fsm <= st_idle;
      end
      else
         s_r <= s_nxt;
   end

   assign mem_req = s_r.mem;
   assign stk_req = s_r.stk;
   assign result = s_r.res;

   // Checks on timing and results
   compare_skip_equal_skip_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_compare_skip_equal && in_instr.rd_val == in_instr.rr_val
       && !in_instr.next_two_words) |-> ##2 !result.done ##1 result.done)
      else $error("compare skip timing wrong");
   regbit_noskip_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_skip_reg_bit_set && !in_instr.rr_val[in_instr.bit_sel])
      |-> ##2 result.done)
      else $error("register bit skip not one cycle");
   iobit_span_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_skip_io_bit_clear) |-> ##1 (!result.done)[*2] ##[1:3] result.done)
      else $error("io bit skip out of span");
   branch_taken_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_branch_flag_set && status_register[in_instr.bit_sel])
      |-> ##1 !result.done ##2 (result.done
      && result.pc_val == $past(in_instr.pc, 3) + {{9{$past(in_instr.offset[6], 3)}},
      $past(in_instr.offset, 3)} + 16'h0001))
      else $error("taken branch target or timing wrong");
   signed_lt_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_branch_signed_lt && !(status_register[`BSLE_STATUS_REGISTER_N] ^ status_register[`BSLE_STATUS_REGISTER_V]))
      |-> ##2 (result.done && result.pc_val == $past(in_instr.pc, 2) + 16'h0001))
      else $error("signed branch taken wrongly");
   direct_load_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_direct_load) |-> ##1 (mem_req.rd && !result.done)
      ##2 (result.done && result.reg_we && !result.status_register_we))
      else $error("direct load wrong");
   load_inc_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_indirect_load_inc) |-> ##2 (result.done && result.ptr_we
      && result.ptr_wdata == $past(in_instr.ptr, 2) + 16'h0001))
      else $error("post increment load wrong");
   load_dec_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_indirect_load_dec) |-> ##1 (mem_req.addr
      == $past(in_instr.ptr) - 16'h0001) ##2 (result.done && result.ptr_wdata == mem_req.addr))
      else $error("pre decrement load wrong");
   interrupt_return_flag_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_interrupt_return) |-> ##1 stk_req.pop
      ##4 (result.done && result.status_register_we && result.status_register_val[`BSLE_STATUS_REGISTER_I]))
      else $error("interrupt return wrong");
   compare_only_a: assert property (@(posedge clk) disable iff (!rstn)
      (take && in_instr.op == op_compare) |-> ##2 (result.done && result.status_register_we
      && !result.reg_we && !result.ptr_we))
      else $error("compare wrote a register");
endmodule // bsle_exec

// ==== bsle_map.svh ====
// Purpose: Constants for the branch, skip and load execution unit
// Assumes: 16-bit program counter, 8-bit data path
// Notes: Status register bit positions and cycle counts follow
`ifndef BSLE_MAP_SVH
`define BSLE_MAP_SVH
`define BSLE_STATUS_REGISTER_C 0
`define BSLE_STATUS_REGISTER_Z 1
`define BSLE_STATUS_REGISTER_N 2
`define BSLE_STATUS_REGISTER_V 3
`define BSLE_STATUS_REGISTER_S 4
`define BSLE_STATUS_REGISTER_H 5
`define BSLE_STATUS_REGISTER_T 6
`define BSLE_STATUS_REGISTER_I 7
`define BSLE_CYC_BRANCH 1
`define BSLE_CYC_SKIP_REG 1
`define BSLE_CYC_SKIP_IO 2
`define BSLE_CYC_LOAD_DIRECT 2
`define BSLE_CYC_LOAD_PLAIN 1
`define BSLE_CYC_LOAD_DEC 2
`define BSLE_CYC_CALL 3
`define BSLE_CYC_RETURN 4
`define BSLE_CYC_COMPARE 1
`endif

// ==== bsle_pkg.sv ====
// Purpose: Types for the branch, skip and load execution unit
// Assumes: Decoder supplies operand values already read
// Notes: Operation codes name the executed instruction
package bsle_pkg;
   typedef enum logic [4:0] {
      op_none, op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
      op_skip_io_bit_clear, op_skip_io_bit_set, op_branch_flag_set, op_branch_flag_clear,
      op_branch_same_higher, op_branch_lower, op_branch_signed_ge, op_branch_signed_lt,
      op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_transfer_bit_set,
      op_branch_transfer_bit_clear, op_branch_overflow_set, op_branch_overflow_clear,
      op_branch_irq_enabled, op_branch_irq_disabled, op_direct_load, op_indirect_load,
      op_indirect_load_inc, op_indirect_load_dec, op_call, op_return,
      op_interrupt_return, op_compare, op_compare_carry, op_compare_imm
   } bsle_op_t;
   typedef enum {st_idle, st_run} bsle_fsm_t;
   typedef struct packed {
      bsle_op_t op;
      logic [15:0] pc;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [6:0] offset;
      logic [15:0] addr;
      logic [15:0] ptr;
      logic next_two_words;
   } bsle_instr_t;
   typedef struct packed {
      logic done;
      logic [15:0] pc_val;
      logic reg_we;
      logic [7:0] reg_wdata;
      logic ptr_we;
      logic [15:0] ptr_wdata;
      logic status_register_we;
      logic [7:0] status_register_val;
   } bsle_result_t;
   typedef struct packed {
      logic rd;
      logic io;
      logic [15:0] addr;
   } bsle_mem_t;
   typedef struct packed {
      logic push;
      logic pop;
      logic [15:0] wdata;
   } bsle_stack_t;
endpackage

// ==== test_branch_skip_load_exec.sv ====
// Purpose: Self-checking bench for the branch, skip and load execution unit
// Assumes: Operands, status and memory data stay steady for a whole instruction
// Notes: Each task drives one group of instructions and judges what comes back
`timescale 1ns/1ps
module test_branch_skip_load_exec;
   import bsle_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic in_valid = 1'b0;
   logic in_ready;
   bsle_instr_t in_instr = '0;
   logic [7:0] status_register = 8'h00;
   logic [7:0] mem_rdata = 8'h00;
   logic [15:0] stk_rdata = 16'h0000;
   bsle_mem_t mem_req;
   bsle_stack_t stk_req;
   bsle_result_t result;
   bsle_result_t got;
   bsle_mem_t seen_mem = '0;
   logic [15:0] seen_push = 16'h0000;
   logic seen_pop = 1'b0;
   int n_fail = 0;
   int comparisons = 0;

   // Clock of 100 ns period
   always #50 clk = ~clk;

   bsle_exec uut (.clk(clk), .rstn(rstn), .in_valid(in_valid), .in_ready(in_ready),
      .in_instr(in_instr), .status_register(status_register), .mem_rdata(mem_rdata), .stk_rdata(stk_rdata),
      .mem_req(mem_req), .stk_req(stk_req), .result(result));

   // Latch the last read request and the last pushed word
   always @(posedge clk)
   begin
      if (mem_req.rd === 1'b1)
         seen_mem <= mem_req;
      if (stk_req.push === 1'b1)
         seen_push <= stk_req.wdata;
      if (stk_req.pop === 1'b1)
         seen_pop <= 1'b1;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_cyc(input int e, input int g);
      comparisons++;
      if (g != e)
      begin
         n_fail++;
         $display("MISMATCH cycles expected %0d seen %0d", e, g);
      end
   endtask

   function automatic bsle_instr_t ins(input bsle_op_t op);
      ins = '0;
      ins.op = op;
      ins.pc = 16'h0100;
   endfunction

   // Subtraction flags as a compare leaves them, T and I passed through
   function automatic logic [7:0] cmp_flags(input logic [7:0] d, input logic [7:0] r,
      input logic [7:0] s, input logic cin, input logic keepz);
      logic [7:0] q;
      logic h, v, c, n, z;
      q = d - r - {7'h00, cin};
      h = (~d[3] & r[3]) | (r[3] & q[3]) | (q[3] & ~d[3]);
      v = (d[7] & ~r[7] & ~q[7]) | (~d[7] & r[7] & q[7]);
      c = (~d[7] & r[7]) | (r[7] & q[7]) | (q[7] & ~d[7]);
      n = q[7];
      z = (q == 8'h00) & (keepz ? s[1] : 1'b1);
      return {s[7:6], h, n ^ v, v, n, z, c};
   endfunction

   // Offer one instruction, count edges from take to done, check cycles and next PC
   task automatic run(input bsle_instr_t i, input logic [7:0] s, input logic [7:0] md,
      input int n_exp, input logic [15:0] pc_exp);
      int cyc;
      @(posedge clk);
      in_valid <= 1'b1;
      in_instr <= i;
      status_register <= s;
      mem_rdata <= md;
      @(posedge clk);
      in_valid <= 1'b0;
      cyc = 0;
      do
      begin
         @(posedge clk);
         #1;
         cyc++;
      end while (result.done !== 1'b1 && cyc < 20);
      got = result;
      chk_cyc(n_exp, cyc);
      chk("pc_val", pc_exp, got.pc_val);
   endtask

   task automatic t_skip_equal();
      bsle_instr_t i;
      i = ins(op_compare_skip_equal);
      i.rd_val = 8'h55;
      i.rr_val = 8'h55;
      run(i, 8'h00, 8'h00, 2, 16'h0102);
      i.next_two_words = 1'b1;
      run(i, 8'h00, 8'h00, 3, 16'h0103);
      i.rr_val = 8'h54;
      run(i, 8'h00, 8'h00, 1, 16'h0101);
      $display("test skip_equal done");
   endtask

   task automatic t_skip_reg();
      bsle_instr_t i;
      for (int b = 0; b < 8; b++)
      begin
         i = ins(op_skip_reg_bit_set);
         i.bit_sel = 3'(b);
         i.rr_val = 8'h01 << b;
         run(i, 8'h00, 8'h00, 2, 16'h0102);
         i.op = op_skip_reg_bit_clear;
         run(i, 8'h00, 8'h00, 1, 16'h0101);
         i.rr_val = ~(8'h01 << b);
         i.next_two_words = 1'b1;
         run(i, 8'h00, 8'h00, 3, 16'h0103);
      end
      $display("test skip_reg done");
   endtask

   task automatic t_skip_io();
      bsle_instr_t i;
      i = ins(op_skip_io_bit_clear);
      i.addr = 16'h003f;
      i.bit_sel = 3'h7;
      run(i, 8'h00, 8'h7f, 3, 16'h0102);
      chk("io", 16'h0001, 16'(seen_mem.io));
      chk("io_addr", 16'h003f, seen_mem.addr);
      i.next_two_words = 1'b1;
      run(i, 8'h00, 8'h7f, 4, 16'h0103);
      i.op = op_skip_io_bit_set;
      run(i, 8'h00, 8'h7f, 2, 16'h0101);
      i.bit_sel = 3'h0;
      i.next_two_words = 1'b0;
      run(i, 8'h00, 8'h01, 3, 16'h0102);
      $display("test skip_io done");
   endtask

   localparam bsle_op_t BR_OP [12] = '{op_branch_same_higher, op_branch_lower,
      op_branch_signed_ge, op_branch_signed_lt, op_branch_halfcarry_set,
      op_branch_halfcarry_clear, op_branch_transfer_bit_set, op_branch_transfer_bit_clear,
      op_branch_overflow_set, op_branch_overflow_clear, op_branch_irq_enabled,
      op_branch_irq_disabled};
   localparam logic [7:0] BR_SR [12] = '{8'h01, 8'h01, 8'h04, 8'h08, 8'h20, 8'h20,
      8'h40, 8'h40, 8'h08, 8'h08, 8'h80, 8'h80};
   localparam logic BR_TK [12] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0,
      1'b1, 1'b0, 1'b1, 1'b0};

   // Generic flag branches with a backward offset, then each named condition
   task automatic t_branch();
      bsle_instr_t i;
      int n_tk;
      logic [15:0] pc_tk;
      for (int s = 0; s < 8; s++)
      begin
         i = ins(op_branch_flag_set);
         i.bit_sel = 3'(s);
         i.offset = 7'h40;
         run(i, 8'h01 << s, 8'h00, 2, 16'h00c1);
         run(i, ~(8'h01 << s), 8'h00, 1, 16'h0101);
         i.op = op_branch_flag_clear;
         run(i, 8'h01 << s, 8'h00, 1, 16'h0101);
         run(i, ~(8'h01 << s), 8'h00, 2, 16'h00c1);
      end
      for (int n = 0; n < 12; n++)
      begin
         i = ins(BR_OP[n]);
         i.offset = 7'h05;
         n_tk = BR_TK[n] ? 2 : 1;
         pc_tk = BR_TK[n] ? 16'h0106 : 16'h0101;
         run(i, BR_SR[n], 8'h00, n_tk, pc_tk);
         n_tk = 3 - n_tk;
         pc_tk = BR_TK[n] ? 16'h0101 : 16'h0106;
         run(i, 8'h00, 8'h00, n_tk, pc_tk);
      end
      i = ins(op_branch_signed_ge);
      run(i, 8'h0c, 8'h00, 2, 16'h0101);
      i.op = op_branch_signed_lt;
      run(i, 8'h0c, 8'h00, 1, 16'h0101);
      $display("test branch done");
   endtask

   // One load with its address, pointer update and register write checked
   task automatic ld(input bsle_op_t op, input logic [15:0] a, input int n, input logic [15:0] pc,
      input logic [15:0] ea, input logic pwe, input logic [15:0] ep);
      bsle_instr_t i;
      i = ins(op);
      i.addr = a;
      i.ptr = a;
      run(i, 8'hff, a[7:0] ^ 8'h5a, n, pc);
      chk("rd_addr", ea, seen_mem.addr);
      chk("rd_io", 16'h0000, 16'(seen_mem.io));
      chk("reg_we", 16'h0001, 16'(got.reg_we));
      chk("reg_wdata", 16'(a[7:0] ^ 8'h5a), 16'(got.reg_wdata));
      chk("status_register_we", 16'h0000, 16'(got.status_register_we));
      chk("ptr_we", 16'(pwe), 16'(got.ptr_we));
      if (pwe)
         chk("ptr_wdata", ep, got.ptr_wdata);
   endtask

   task automatic t_loads();
      ld(op_direct_load, 16'h2345, 2, 16'h0102, 16'h2345, 1'b0, 16'h0000);
      ld(op_indirect_load, 16'h1234, 1, 16'h0101, 16'h1234, 1'b0, 16'h0000);
      ld(op_indirect_load_inc, 16'hffff, 1, 16'h0101, 16'hffff, 1'b1, 16'h0000);
      ld(op_indirect_load_dec, 16'h0000, 2, 16'h0101, 16'hffff, 1'b1, 16'hffff);
      $display("test loads done");
   endtask

   task automatic t_call_ret();
      bsle_instr_t i;
      i = ins(op_call);
      i.addr = 16'h3000;
      run(i, 8'h00, 8'h00, 3, 16'h3000);
      chk("push", 16'h0102, seen_push);
      chk("pop_early", 16'h0000, 16'(seen_pop));
      @(posedge clk);
      stk_rdata <= 16'h0abc;
      run(ins(op_return), 8'h03, 8'h00, 4, 16'h0abc);
      chk("status_register_we", 16'h0000, 16'(got.status_register_we));
      chk("pop", 16'h0001, 16'(seen_pop));
      run(ins(op_interrupt_return), 8'h03, 8'h00, 4, 16'h0abc);
      chk("status_register_we", 16'h0001, 16'(got.status_register_we));
      chk("status_register_val", 16'h0083, {8'h00, got.status_register_val});
      $display("test call_ret done");
   endtask

   // One compare: flags written, no register touched, one cycle
   task automatic cmp1(input bsle_op_t op, input logic [7:0] d, input logic [7:0] r,
      input logic [7:0] s);
      bsle_instr_t i;
      logic cy;
      i = ins(op);
      i.rd_val = d;
      i.rr_val = r;
      i.imm = r;
      cy = (op == op_compare_carry);
      run(i, s, 8'h00, 1, 16'h0101);
      chk("status_register_val", 16'(cmp_flags(d, r, s, cy & s[0], cy)), 16'(got.status_register_val));
      chk("status_register_we", 16'h0001, 16'(got.status_register_we));
      chk("reg_we", 16'h0000, 16'(got.reg_we));
   endtask

   task automatic t_compare();
      logic [7:0] d [4] = '{8'h10, 8'h00, 8'h80, 8'h3f};
      logic [7:0] r [4] = '{8'h10, 8'h01, 8'h01, 8'h40};
      for (int n = 0; n < 4; n++)
      begin
         cmp1(op_compare, d[n], r[n], 8'h43);
         cmp1(op_compare_imm, d[n], r[n], 8'h80);
         cmp1(op_compare_carry, d[n], r[n], 8'h43);
         cmp1(op_compare_carry, d[n], r[n], 8'h40);
      end
      $display("test compare done");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #2000000;
      n_fail++;
      end_of_test();
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("idle_ready", 16'h0001, 16'(in_ready));
      chk("idle_done", 16'h0000, 16'(result.done));
      t_skip_equal();
      t_skip_reg();
      t_skip_io();
      t_branch();
      t_loads();
      t_call_ret();
      t_compare();
      end_of_test();
   end
endmodule // test_branch_skip_load_exec
